// file: ssr_status_readout.sv
// Status readout and clear logic behind a 16-bit daisy-chain SPI slave.
// Assumes SPI pins come from outside and are resynchronised to sys_clk,
// and that fault events come from protection logic on sys_clk.
`timescale 1ns/100ps

module ssr_status_readout
  import ssr_pkg::*;
(
  input  wire logic                                    sys_clk,
  input  wire logic                                    rstn,
  input  wire logic                                    spi_clk,
  input  wire logic                                    chip_select_n,
  input  wire logic                                    spi_di,
  output logic                                         spi_do,
  output logic                                         spi_do_oe_n,
  input  wire logic [ssr_pkg::NUM_REGS*ssr_pkg::FLAG_W-1:0] fault_set,
  input  wire logic                                    supply_fail_flag,
  input  wire logic                                    thermal_shutdown_event,
  input  wire logic                                    thermal_warning_flag,
  output logic [ssr_pkg::STAT_W-1:0]                   ctrl_word,
  output logic                                         ctrl_valid,
  output logic [ssr_pkg::SEL_W-1:0]                    register_select_bits,
  output logic [ssr_pkg::NUM_REGS*ssr_pkg::FLAG_W-1:0] latched_flags,
  output logic                                         thermal_shutdown_flag,
  output logic                                         combined_error_flag
);

  import ssr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic       clk_prev_q;
  logic       cs_prev_q;

  // Two stages before any logic reads a pin
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_q <= 3'h7;
    end else begin
      pin_meta_q <= {spi_di, chip_select_n, spi_clk};
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_sync_q <= 3'h7;
    end else begin
      pin_sync_q <= pin_meta_q;
    end
  end

  // History idles high; a low clock pin after reset gives a false
  // falling edge only while chip select is high, where it is ignored
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clk_prev_q <= 1'b1;
    end else begin
      clk_prev_q <= pin_sync_q[0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= pin_sync_q[1];
    end
  end

  wire clk_s   = pin_sync_q[0];
  wire cs_n_s  = pin_sync_q[1];
  wire di_s    = pin_sync_q[2];
  wire clk_up  = clk_s & ~clk_prev_q & ~cs_n_s;
  wire clk_dn  = ~clk_s & clk_prev_q & ~cs_n_s;
  wire cs_fall = ~cs_n_s & cs_prev_q;
  wire cs_rise = cs_n_s & ~cs_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Error flag storage

  logic [NUM_REGS*FLAG_W-1:0] flags_q;
  logic [NUM_REGS*FLAG_W-1:0] flags_d;
  logic                       tsd_q;
  logic                       tsd_d;
  logic [SEL_W-1:0]           sel_q;
  logic [SEL_W-1:0]           sel_d;
  logic                       pend_clear_q;
  logic                       pend_clear_d;
  logic                       seen_q;
  logic                       seen_d;
  logic [NUM_REGS-1:0]        summary;
  logic [STAT_W-1:0]          stat_word [NUM_REGS];

  // Frames with no clock are only error-flag peeks, not commands
  wire frame_end = cs_rise & seen_q;
  // Clear acts on the register just read out, then the new command lands
  wire clear_now = frame_end & pend_clear_q;

  // Summaries of the other registers, highest address first
  function automatic logic [2:0] others(input int r,
                                        input logic [NUM_REGS-1:0] s);
    logic [2:0] v;
    int         k;
    v = 3'h0;
    k = 2;
    for (int i = NUM_REGS - 1; i >= 0; i--) begin
      if (i != r) begin
        v[k] = s[i];
        k = k - 1;
      end
    end
    return v;
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      wire [FLAG_W-1:0] cur = flags_q[g*FLAG_W +: FLAG_W];
      wire [FLAG_W-1:0] mask = CONN_MASK[g*FLAG_W +: FLAG_W];
      wire [FLAG_W-1:0] set = fault_set[g*FLAG_W +: FLAG_W] & mask;
      wire clr = clear_now & (sel_q == SEL_W'(g));
      // Set wins over a clear in the same cycle
      assign flags_d[g*FLAG_W +: FLAG_W] =
        (cur & ~{FLAG_W{clr}}) | set;
      assign summary[g] = |cur;
      assign stat_word[g] = {cur,
                             supply_fail_flag,
                             tsd_q,
                             thermal_warning_flag,
                             others(g, summary)};
    end
  endgenerate

  // Summaries see only latched flags; live supply and warning levels
  // would otherwise keep a just-cleared register looking faulty
  assign tsd_d = (tsd_q & ~clear_now) | thermal_shutdown_event;
  assign combined_error_flag = |summary;

  ////////////////////////////////////////////////////////////////////////////
  // Command capture at the end of a frame

  logic [STAT_W-1:0] shift_q;
  logic [STAT_W-1:0] shift_d;
  logic [STAT_W-1:0] ctrl_q;
  logic [STAT_W-1:0] ctrl_d;
  logic              valid_q;
  logic              valid_d;

  // Command fields only move at a real frame end, never mid-frame
  assign sel_d = frame_end ? shift_q[SEL_MSB:SEL_LSB] : sel_q;
  assign pend_clear_d = frame_end ? shift_q[CLEAR_BIT]
                                  : pend_clear_q;
  assign ctrl_d  = frame_end ? shift_q : ctrl_q;
  assign valid_d = frame_end;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tsd_q <= 1'b0;
    end else begin
      tsd_q <= tsd_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= SELECT_RESET;
    end else begin
      sel_q <= sel_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pend_clear_q <= 1'b0;
    end else begin
      pend_clear_q <= pend_clear_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= WORD_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial shift path

  logic miso_q;
  logic miso_d;
  logic oe_n_q;
  logic oe_n_d;

  // Driver let go one cycle after the synced select rises
  assign oe_n_d = cs_n_s;

  // One register holds the outgoing word and fills with incoming bits,
  // so words longer than 16 bits pass straight through a chain
  assign shift_d = cs_fall ? stat_word[sel_q]
                 : clk_dn  ? {shift_q[STAT_W-2:0], di_s}
                 : shift_q;

  assign seen_d = cs_fall ? 1'b0 : (clk_up ? 1'b1 : seen_q);

  // Error flag stays live until the first rising clock edge
  assign miso_d = (cs_fall | (~cs_n_s & ~seen_q & ~clk_up))
                ? combined_error_flag
                : clk_up ? shift_q[STAT_W-1]
                : miso_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= WORD_RESET;
    end else begin
      shift_q <= shift_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= seen_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= miso_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= oe_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign spi_do                = miso_q;
  assign spi_do_oe_n           = oe_n_q;
  assign ctrl_word             = ctrl_q;
  assign ctrl_valid            = valid_q;
  assign register_select_bits  = sel_q;
  assign latched_flags         = flags_q;
  assign thermal_shutdown_flag = tsd_q;

endmodule

// file: ssr_pkg.sv
// Constants for the SPI status readout block.
// Assumes users on the system clock: the readout module, its monitor and the bench.
package ssr_pkg;

  // Frame and register geometry
  localparam int STAT_W   = 16;
  localparam int FLAG_W   = 10;
  localparam int NUM_REGS = 4;
  localparam int SEL_W    = 2;

  // Field positions inside a status word
  localparam int FLAG_LSB         = 6;
  localparam int SUPPLY_FAIL_BIT  = 5;
  localparam int THERMAL_SD_BIT   = 4;
  localparam int THERMAL_WARN_BIT = 3;
  localparam int SUMMARY_MSB      = 2;

  // Field positions inside a received command word
  localparam int SEL_MSB   = 15;
  localparam int SEL_LSB   = 14;
  localparam int CLEAR_BIT = 13;

  // Register offsets
  localparam logic [SEL_W-1:0] BRIDGE_OVERLOAD_STATUS = 2'h0;
  localparam logic [SEL_W-1:0] BRIDGE_OPENLOAD_STATUS = 2'h1;
  localparam logic [SEL_W-1:0] LAMP_OVERLOAD_STATUS   = 2'h2;
  localparam logic [SEL_W-1:0] LAMP_OPENLOAD_STATUS   = 2'h3;

  // Connected flag positions (bits 15..6), register 3 in the top slice
  localparam logic [NUM_REGS*FLAG_W-1:0] CONN_MASK =
    {10'h2af, 10'h3ff, 10'h2a8, 10'h3f8};

  // Reset values
  localparam logic [SEL_W-1:0]           SELECT_RESET = BRIDGE_OVERLOAD_STATUS;
  localparam logic [NUM_REGS*FLAG_W-1:0] FLAGS_RESET  = 40'h00_0000_0000;
  localparam logic [STAT_W-1:0]          WORD_RESET   = 16'h0000;

endpackage

// file: ssr_status_monitor.sv
// Checker for the status readout block.
// Assumes it is bound onto ssr_status_readout.
`timescale 1ns/100ps
module ssr_status_monitor
  import ssr_pkg::*;
(
  input wire logic                                         sys_clk,
  input wire logic                                         rstn,
  input wire logic                                         chip_select_n,
  input wire logic                                         spi_do_oe_n,
  input wire logic [ssr_pkg::NUM_REGS*ssr_pkg::FLAG_W-1:0] fault_set,
  input wire logic                                         thermal_shutdown_event,
  input wire logic                                         ctrl_valid,
  input wire logic [ssr_pkg::NUM_REGS*ssr_pkg::FLAG_W-1:0] latched_flags,
  input wire logic                                         thermal_shutdown_flag,
  input wire logic                                         combined_error_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  chk_error_or: assert property (
    combined_error_flag == |latched_flags)
    else $error("combined error flag differs from flags");
  chk_nc_low: assert property ((latched_flags & ~CONN_MASK) == '0)
    else $error("unconnected status bit set");
  chk_flag_sets: assert property (
    |(fault_set & CONN_MASK) |=>
      ((latched_flags & $past(fault_set & CONN_MASK))
        == $past(fault_set & CONN_MASK)))
    else $error("fault event not latched");
  chk_flag_hold: assert property (
    ((~latched_flags & $past(latched_flags)) != '0) |-> ctrl_valid)
    else $error("flag dropped without clear");
  chk_tsd_set: assert property (
    thermal_shutdown_event |=> thermal_shutdown_flag)
    else $error("thermal shutdown not latched");
  chk_tsd_clear: assert property (
    $fell(thermal_shutdown_flag) |-> ctrl_valid)
    else $error("thermal shutdown dropped outside clear");
  chk_valid_pulse: assert property (ctrl_valid |=> !ctrl_valid)
    else $error("command pulse too long");
  chk_valid_idle: assert property (ctrl_valid |-> chip_select_n)
    else $error("command taken inside frame");
  chk_oe_idle: assert property (chip_select_n [*5] |-> spi_do_oe_n)
    else $error("output driven while deselected");
  cover property (ctrl_valid);
  cover property ($fell(thermal_shutdown_flag));
  cover property (combined_error_flag && !spi_do_oe_n);
endmodule

// file: ssr_spi_master.sv
// SPI master model for the status readout port.
// Assumes clock idle low, data launched on rising, sampled on falling.
`timescale 1ns/100ps
module ssr_spi_master (
  output logic      spi_clk,
  output logic      chip_select_n,
  output logic      spi_di,
  input  wire logic spi_do_wire
);
  localparam int HALF = 24;
  initial begin
    spi_clk = 1'b0;
    chip_select_n = 1'b1;
    spi_di = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Clock stands low outside frames
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx,
                       output logic ef);
    integer i;
    chip_select_n = 1'b0;
    #(2*HALF);
    ef = spi_do_wire;
    for (i = 15; i >= 0; i--) begin
      spi_clk = 1'b1;
      spi_di = tx[i];
      #HALF;
      spi_clk = 1'b0;
      rx[i] = spi_do_wire;
      #HALF;
    end
    chip_select_n = 1'b1;
    spi_di = ~spi_di; // No stale bit once released
    #(4*HALF);
  endtask
  // Select pulse with no clock: error flag only, no command
  task automatic peek(output logic ef);
    chip_select_n = 1'b0;
    #(2*HALF);
    ef = spi_do_wire;
    chip_select_n = 1'b1;
    #(4*HALF);
  endtask
endmodule

// file: ssr_status_readout_tb_top.sv
// Self-checking bench for the status readout block.
// Assumes the master model and monitor are compiled first.
`timescale 1ns/100ps
module ssr_status_readout_tb_top;
  import ssr_pkg::*;
  logic        sys_clk, rstn, spi_clk, chip_select_n, spi_di, spi_do;
  logic        spi_do_oe_n, supply_fail_flag, thermal_shutdown_event;
  logic        thermal_warning_flag, ctrl_valid, thermal_shutdown_flag;
  logic        combined_error_flag, ef;
  logic [39:0] fault_set, latched_flags;
  logic [15:0] ctrl_word, rx;
  logic [1:0]  register_select_bits;
  int          bad_count = 0, compares = 0, cyc = 0;
  wire         spi_do_wire = spi_do_oe_n ? 1'bz : spi_do;
  ssr_status_readout u_ssr_status_readout (.sys_clk(sys_clk), .rstn(rstn),
    .spi_clk(spi_clk), .chip_select_n(chip_select_n), .spi_di(spi_di),
    .spi_do(spi_do), .spi_do_oe_n(spi_do_oe_n), .fault_set(fault_set),
    .supply_fail_flag(supply_fail_flag),
    .thermal_shutdown_event(thermal_shutdown_event),
    .thermal_warning_flag(thermal_warning_flag), .ctrl_word(ctrl_word),
    .ctrl_valid(ctrl_valid), .register_select_bits(register_select_bits),
    .latched_flags(latched_flags),
    .thermal_shutdown_flag(thermal_shutdown_flag),
    .combined_error_flag(combined_error_flag));
  ssr_spi_master u_ssr_spi_master (.spi_clk(spi_clk),
    .chip_select_n(chip_select_n), .spi_di(spi_di),
    .spi_do_wire(spi_do_wire));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Default select reads register 00 first
  task automatic t_first_read;
    u_ssr_spi_master.frame(16'h4000, rx, ef);
    check(rx, 16'h0000);
    check(ef, 1'b0);
    check(register_select_bits, 2'h1);
    check(ctrl_word, 16'h4000);
  endtask
  // Clear must wait one frame so the data is read first
  task automatic t_fault_clear;
    @(negedge sys_clk);
    fault_set = 40'h00_0000_0201;
    thermal_shutdown_event = 1'b1;
    supply_fail_flag = 1'b1;
    thermal_warning_flag = 1'b1;
    @(negedge sys_clk);
    fault_set = '0;
    thermal_shutdown_event = 1'b0;
    check(latched_flags[9:0], 10'h200);
    u_ssr_spi_master.peek(ef);
    check(ef, 1'b1);
    check(register_select_bits, 2'h1);
    u_ssr_spi_master.frame(16'h2000, rx, ef);
    check(rx, 16'h0039);
    check(ef, 1'b1);
    check(latched_flags[9], 1'b1);
    u_ssr_spi_master.frame(16'h0000, rx, ef);
    check(rx, 16'h8038);
    check({latched_flags[9], thermal_shutdown_flag}, 2'b00);
    u_ssr_spi_master.frame(16'h0000, rx, ef);
    check(rx, 16'h0028);
    check(ef, 1'b0);
    @(negedge sys_clk);
    supply_fail_flag = 1'b0;
    thermal_warning_flag = 1'b0;
  endtask
  // Cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      end_sim;
    end
  end
  initial begin
    rstn = 1'b0;
    fault_set = '0;
    supply_fail_flag = 1'b0;
    thermal_shutdown_event = 1'b0;
    thermal_warning_flag = 1'b0;
    repeat (16) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_first_read;
    t_fault_clear;
    end_sim;
  end
endmodule
bind ssr_status_readout ssr_status_monitor u_ssr_status_monitor (
  .sys_clk(sys_clk), .rstn(rstn), .chip_select_n(chip_select_n),
  .spi_do_oe_n(spi_do_oe_n), .fault_set(fault_set),
  .thermal_shutdown_event(thermal_shutdown_event), .ctrl_valid(ctrl_valid),
  .latched_flags(latched_flags), .thermal_shutdown_flag(thermal_shutdown_flag),
  .combined_error_flag(combined_error_flag));
